// ---- rtl/apcd_pkg.sv ----
package apcd_pkg;
	// ------------------------------------------------------------
	// register indices (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_SRC_SEL    = 8'h19;
	localparam logic [7:0] IDX_BIT_DIV    = 8'h1a;
	localparam logic [7:0] IDX_WORD_DIV   = 8'h1b;
	localparam logic [7:0] IDX_PULSE_DENSITY_CONFIG    = 8'h1c;
	localparam logic [7:0] IDX_PULSE_DENSITY_DIVIDER    = 8'h1d;
	localparam logic [7:0] IDX_STREAM_DIV = 8'h1e;
	localparam logic [7:0] IDX_SERIAL_CFG = 8'h18;
	localparam logic [7:0] IDX_STATUS     = 8'h1f;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_SRC_SEL    = 8'h00;
	localparam logic [7:0] RST_BIT_DIV    = 8'h01;
	localparam logic [7:0] RST_WORD_DIV   = 8'h40;
	localparam logic [7:0] RST_PULSE_DENSITY_CONFIG    = 8'h00;
	localparam logic [7:0] RST_PULSE_DENSITY_DIVIDER    = 8'h08;
	localparam logic [7:0] RST_STREAM_DIV = 8'h08;
	localparam logic [7:0] RST_SERIAL_CFG = 8'h00;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int POS_POWER      = 7;
	localparam int POS_EDGE       = 2;
	localparam int POS_IN_DIR     = 1;
	localparam int POS_OUT_DIR    = 0;
	localparam int POS_WORD_DIR   = 5;
	localparam int POS_BIT_DIR    = 4;
	localparam int RATIO_W        = 7;
	localparam logic [6:0] RATIO_MIN_CODE = 7'h20;
	localparam logic [7:0] RATIO_ZERO_DIV = 8'h80;

	// clock source selector codes
	typedef enum logic [1:0] {
		SRC_DAC_MOD,
		SRC_ADC_MOD,
		SRC_PLL_NDIV,
		SRC_RESERVED
	} apcd_src_t;
endpackage

// ---- rtl/apcd_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
module apcd_divider #(
	parameter int RW = 7
) (
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire logic          tickIn,
	input  wire logic          powerUp,
	input  wire logic [RW-1:0] ratioCode,
	output logic               divClk,
	output logic               divTick,
	output logic               ratioValid
);
	logic [RW:0] cnt_q;
	logic [RW:0] cnt_d;
	logic        clk_q;
	logic        clk_d;
	logic [RW:0] divisor;

	// ------------------------------------------------------------
	// ratio decode: 0 means the largest division
	// ------------------------------------------------------------
	function automatic logic [RW:0] ratio_of(input logic [RW-1:0] code);
		if (code == '0) begin
			return apcd_pkg::RATIO_ZERO_DIV;
		end
		return {1'b0, code};
	endfunction

	assign divisor    = ratio_of(ratioCode);
	assign ratioValid = (ratioCode == '0) || (ratioCode >= apcd_pkg::RATIO_MIN_CODE);

	// counter: held cleared and output low while powered down
	always_comb begin
		cnt_d = cnt_q;
		clk_d = clk_q;
		if (!powerUp || !ratioValid) begin
			cnt_d = '0;
			clk_d = 1'b0;
		end else if (tickIn) begin
			if (cnt_q >= divisor - 8'(1)) begin
				cnt_d = '0;
			end else begin
				cnt_d = cnt_q + 8'(1);
			end
			// high for the first half; odd ratios get the shorter high half
			clk_d = (cnt_d < (divisor >> 1));
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			clk_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			clk_q <= clk_d;
		end
	end

	assign divClk  = clk_q;
	assign divTick = powerUp && ratioValid && tickIn && (cnt_q >= divisor - 8'(1));

	AST_HELD_DOWN: assert property (@(posedge clk_sys) disable iff (rst)
		!powerUp |=> (cnt_q == '0) && !divClk)
		else $error("divider not held cleared while powered down");
	AST_WRAP: assert property (@(posedge clk_sys) disable iff (rst)
		divTick |=> cnt_q == '0)
		else $error("divider did not wrap at ratio");
endmodule
`default_nettype wire

// ---- rtl/apcd_top.sv ----
// How it works
// - selector picks the bit divider clock; word divider divides the bit clock
// - bit divider power bit seven
// - bit ratio: 0 is 128, 32-127 literal
// - word divider power bit seven
// - word ratio same mapping, resets to 40h
// - pdm data sampled rising or falling edge
// - pdm in/out clock direction bits
// - pdm input divider power bit seven
// - bitstream divider power bit seven
// - bit clock direction: input or output
// - word clock direction: input or output
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module apcd_top (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// candidate divider input ticks, one-cycle enables
	input  wire logic        dacModTick,
	input  wire logic        adcModTick,
	input  wire logic        pllNdivTick,
	// serial port clocks
	output logic             bitClkOut,
	output logic             bitClkOe,
	output logic             wordClkOut,
	output logic             wordClkOe,
	// pdm clocks and data
	input  wire logic        densityInClkIn,
	output logic             densityInClkOut,
	output logic             densityInClkOe,
	input  wire logic        densityOutClkIn,
	output logic             densityOutClkOut,
	output logic             densityOutClkOe,
	input  wire logic        densityData,
	output logic             densitySample,
	output logic             densitySampleValid,
	// power enables of the pdm and bitstream dividers
	output logic             densityDividerPower,
	output logic             bitstreamDividerPower
);
	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [7:0] srcSel_q, srcSel_d;
	logic [7:0] bitDiv_q, bitDiv_d;
	logic [7:0] wordDiv_q, wordDiv_d;
	logic [7:0] pdmCfg_q, pdmCfg_d;
	logic [7:0] pdmDiv_q, pdmDiv_d;
	logic [7:0] streamDiv_q, streamDiv_d;
	logic [7:0] serialCfg_q, serialCfg_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pslverr_q, pslverr_d;
	logic [9:0]  regIdx;
	logic        access;
	logic        hit;
	logic        bitClk, wordClk, bitTick, wordTick, bitOk, wordOk;
	logic        divInTick;

	assign regIdx = paddr[11:2];
	assign access = psel && penable;

	// function: is this word index one of ours
	function automatic logic idx_hit(input logic [9:0] idx);
		return idx == 10'(apcd_pkg::IDX_SRC_SEL) || idx == 10'(apcd_pkg::IDX_BIT_DIV)
			|| idx == 10'(apcd_pkg::IDX_WORD_DIV) || idx == 10'(apcd_pkg::IDX_PULSE_DENSITY_CONFIG)
			|| idx == 10'(apcd_pkg::IDX_PULSE_DENSITY_DIVIDER) || idx == 10'(apcd_pkg::IDX_STREAM_DIV)
			|| idx == 10'(apcd_pkg::IDX_SERIAL_CFG) || idx == 10'(apcd_pkg::IDX_STATUS);
	endfunction

	assign hit = idx_hit(regIdx) && paddr[1:0] == 2'h0;

	// write and read decode; only byte lane 0 carries data
	always_comb begin
		srcSel_d    = srcSel_q;
		bitDiv_d    = bitDiv_q;
		wordDiv_d   = wordDiv_q;
		pdmCfg_d    = pdmCfg_q;
		pdmDiv_d    = pdmDiv_q;
		streamDiv_d = streamDiv_q;
		serialCfg_d = serialCfg_q;
		prdata_d    = prdata_q;
		pslverr_d   = 1'b0;
		if (psel && !penable) begin
			pslverr_d = !hit || (pwrite && regIdx == 10'(apcd_pkg::IDX_STATUS));
			prdata_d  = 32'h0000_0000;
			if (!pwrite) begin
				if (regIdx == 10'(apcd_pkg::IDX_SRC_SEL)) begin
					prdata_d[7:0] = srcSel_q;
				end else if (regIdx == 10'(apcd_pkg::IDX_BIT_DIV)) begin
					prdata_d[7:0] = bitDiv_q;
				end else if (regIdx == 10'(apcd_pkg::IDX_WORD_DIV)) begin
					prdata_d[7:0] = wordDiv_q;
				end else if (regIdx == 10'(apcd_pkg::IDX_PULSE_DENSITY_CONFIG)) begin
					prdata_d[7:0] = pdmCfg_q;
				end else if (regIdx == 10'(apcd_pkg::IDX_PULSE_DENSITY_DIVIDER)) begin
					prdata_d[7:0] = pdmDiv_q;
				end else if (regIdx == 10'(apcd_pkg::IDX_STREAM_DIV)) begin
					prdata_d[7:0] = streamDiv_q;
				end else if (regIdx == 10'(apcd_pkg::IDX_SERIAL_CFG)) begin
					prdata_d[7:0] = serialCfg_q;
				end else if (regIdx == 10'(apcd_pkg::IDX_STATUS)) begin
					// live divider state for software
					prdata_d[5:0] = {wordOk, bitOk, wordClk, bitClk,
						densityDividerPower, bitstreamDividerPower};
				end
			end
		end
		if (access && pwrite && hit && pstrb[0]) begin
			if (regIdx == 10'(apcd_pkg::IDX_SRC_SEL)) begin
				srcSel_d = pwdata[7:0];
			end else if (regIdx == 10'(apcd_pkg::IDX_BIT_DIV)) begin
				bitDiv_d = pwdata[7:0];
			end else if (regIdx == 10'(apcd_pkg::IDX_WORD_DIV)) begin
				wordDiv_d = pwdata[7:0];
			end else if (regIdx == 10'(apcd_pkg::IDX_PULSE_DENSITY_CONFIG)) begin
				pdmCfg_d = pwdata[7:0];
			end else if (regIdx == 10'(apcd_pkg::IDX_PULSE_DENSITY_DIVIDER)) begin
				pdmDiv_d = pwdata[7:0];
			end else if (regIdx == 10'(apcd_pkg::IDX_STREAM_DIV)) begin
				streamDiv_d = pwdata[7:0];
			end else if (regIdx == 10'(apcd_pkg::IDX_SERIAL_CFG)) begin
				serialCfg_d = pwdata[7:0];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			srcSel_q    <= apcd_pkg::RST_SRC_SEL;
			bitDiv_q    <= apcd_pkg::RST_BIT_DIV;
			wordDiv_q   <= apcd_pkg::RST_WORD_DIV;
			pdmCfg_q    <= apcd_pkg::RST_PULSE_DENSITY_CONFIG;
			pdmDiv_q    <= apcd_pkg::RST_PULSE_DENSITY_DIVIDER;
			streamDiv_q <= apcd_pkg::RST_STREAM_DIV;
			serialCfg_q <= apcd_pkg::RST_SERIAL_CFG;
			prdata_q    <= 32'h0000_0000;
			pslverr_q   <= 1'b0;
		end else begin
			srcSel_q    <= srcSel_d;
			bitDiv_q    <= bitDiv_d;
			wordDiv_q   <= wordDiv_d;
			pdmCfg_q    <= pdmCfg_d;
			pdmDiv_q    <= pdmDiv_d;
			streamDiv_q <= streamDiv_d;
			serialCfg_q <= serialCfg_d;
			prdata_q    <= prdata_d;
			pslverr_q   <= pslverr_d;
		end
	end

	// zero-wait answer; data captured in setup
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = access && pslverr_q;

	// ------------------------------------------------------------
	// source selection
	// ------------------------------------------------------------
	// reserved code gives no ticks, so dividers simply stall
	always_comb begin
		case (apcd_src_sel(srcSel_q[1:0]))
			apcd_pkg::SRC_DAC_MOD:  divInTick = dacModTick;
			apcd_pkg::SRC_ADC_MOD:  divInTick = adcModTick;
			apcd_pkg::SRC_PLL_NDIV: divInTick = pllNdivTick;
			default:                divInTick = 1'b0;
		endcase
	end

	function automatic apcd_pkg::apcd_src_t apcd_src_sel(input logic [1:0] code);
		return apcd_pkg::apcd_src_t'(code);
	endfunction

	// ------------------------------------------------------------
	// dividers; word divider counts bit clock periods
	// ------------------------------------------------------------
	apcd_divider #(.RW(apcd_pkg::RATIO_W)) bitDivider (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.tickIn     (divInTick),
		.powerUp    (bitDiv_q[apcd_pkg::POS_POWER]),
		.ratioCode  (bitDiv_q[6:0]),
		.divClk     (bitClk),
		.divTick    (bitTick),
		.ratioValid (bitOk)
	);

	apcd_divider #(.RW(apcd_pkg::RATIO_W)) wordDivider (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.tickIn     (bitTick),
		.powerUp    (wordDiv_q[apcd_pkg::POS_POWER]),
		.ratioCode  (wordDiv_q[6:0]),
		.divClk     (wordClk),
		.divTick    (wordTick),
		.ratioValid (wordOk)
	);

	// pin drive: an input-mode clock is left to the host
	assign bitClkOut  = bitClk;
	assign bitClkOe   = serialCfg_q[apcd_pkg::POS_BIT_DIR];
	assign wordClkOut = wordClk;
	assign wordClkOe  = serialCfg_q[apcd_pkg::POS_WORD_DIR];

	// ------------------------------------------------------------
	// pdm section
	// ------------------------------------------------------------
	logic inClk_q, inClk_d, smp_q, smp_d, smpV_q, smpV_d;
	logic pdmClk;

	assign densityDividerPower   = pdmDiv_q[apcd_pkg::POS_POWER];
	assign bitstreamDividerPower = streamDiv_q[apcd_pkg::POS_POWER];
	assign densityInClkOe        = pdmCfg_q[apcd_pkg::POS_IN_DIR];
	assign densityOutClkOe       = pdmCfg_q[apcd_pkg::POS_OUT_DIR];
	// driven pdm clocks reuse the bit clock, gated by divider power
	assign densityInClkOut       = bitClk && densityDividerPower;
	assign densityOutClkOut      = bitClk && densityDividerPower;
	assign pdmClk = densityInClkOe ? densityInClkOut : densityInClkIn;

	// edge detect on the selected pdm clock, then sample data
	always_comb begin
		inClk_d = pdmClk;
		smp_d   = smp_q;
		smpV_d  = 1'b0;
		if (pdmCfg_q[apcd_pkg::POS_EDGE] ? (inClk_q && !pdmClk)
				: (!inClk_q && pdmClk)) begin
			smp_d  = densityData;
			smpV_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			inClk_q <= 1'b0;
			smp_q   <= 1'b0;
			smpV_q  <= 1'b0;
		end else begin
			inClk_q <= inClk_d;
			smp_q   <= smp_d;
			smpV_q  <= smpV_d;
		end
	end

	assign densitySample      = smp_q;
	assign densitySampleValid = smpV_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_SRC_ROUTE: assert property (@(posedge clk_sys) disable iff (rst)
		srcSel_q[1:0] == 2'h3 |-> !divInTick)
		else $error("reserved source passed a tick");
	AST_BIT_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		!bitDiv_q[7] ##1 !bitDiv_q[7] |-> !bitClk)
		else $error("bit clock toggled while powered down");
	AST_WORD_OFF: assert property (@(posedge clk_sys) disable iff (rst)
		!wordDiv_q[7] ##1 !wordDiv_q[7] |-> !wordClk)
		else $error("word clock toggled while powered down");
	AST_RES_RATIO: assert property (@(posedge clk_sys) disable iff (rst)
		bitDiv_q[6:0] inside {[7'h01:7'h1f]} |-> !bitTick)
		else $error("reserved bit ratio divided");
	AST_WORD_RATIO: assert property (@(posedge clk_sys) disable iff (rst)
		wordDiv_q[6:0] inside {[7'h01:7'h1f]} |-> !wordTick)
		else $error("reserved word ratio divided");
	AST_RISE_SAMPLE: assert property (@(posedge clk_sys) disable iff (rst)
		!pdmCfg_q[2] && $stable(pdmCfg_q) && $rose(pdmClk)
			|=> densitySampleValid && densitySample == $past(densityData))
		else $error("rising edge sample missed");
	AST_FALL_SAMPLE: assert property (@(posedge clk_sys) disable iff (rst)
		pdmCfg_q[2] && $stable(pdmCfg_q) && $fell(pdmClk)
			|=> densitySampleValid && densitySample == $past(densityData))
		else $error("falling edge sample missed");
	// an accepted write to the pdm config must apply both directions in the next cycle
	AST_PDM_DIR: assert property (@(posedge clk_sys) disable iff (rst)
		access && pwrite && hit && pstrb[0] && regIdx == 10'(apcd_pkg::IDX_PULSE_DENSITY_CONFIG)
			|=> densityInClkOe == $past(pwdata[1]) && densityOutClkOe == $past(pwdata[0]))
		else $error("pdm direction not applied");
	AST_PDM_PWR: assert property (@(posedge clk_sys) disable iff (rst)
		!densityDividerPower |-> !densityInClkOut && !densityOutClkOut)
		else $error("pdm clock driven while divider down");
	AST_DIRS: assert property (@(posedge clk_sys) disable iff (rst)
		access && pwrite && hit && pstrb[0] && regIdx == 10'(apcd_pkg::IDX_SERIAL_CFG)
			|=> bitClkOe == $past(pwdata[4]) && wordClkOe == $past(pwdata[5]))
		else $error("serial clock direction wrong");
	AST_STREAM: assert property (@(posedge clk_sys) disable iff (rst)
		access && pwrite && hit && pstrb[0] && regIdx == 10'(apcd_pkg::IDX_STREAM_DIV)
			|=> bitstreamDividerPower == $past(pwdata[7]))
		else $error("bitstream power wrong");

	COV_BIT_RUN: cover property (@(posedge clk_sys) disable iff (rst) $rose(bitClk));
	COV_WORD_RUN: cover property (@(posedge clk_sys) disable iff (rst) $rose(wordClk));
	COV_PDM_FALL: cover property (@(posedge clk_sys) disable iff (rst)
		pdmCfg_q[2] && densitySampleValid);
	COV_BAD_ADDR: cover property (@(posedge clk_sys) disable iff (rst) pslverr);
endmodule
`default_nettype wire

// ---- verification/apcd_pdm_source.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// pdm source model: far-side clocks and data
// ------------------------------------------------------------
module apcd_pdm_source #(
	parameter int HALF = 4
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic run,
	input  wire logic inClkOe,
	input  wire logic outClkOe,
	output logic      inClk,
	output logic      outClk,
	output logic      data
);
	int          phase;
	logic [15:0] pat;

	// clocks stand still between frames; a pin the device owns is fed
	// a level that flips every cycle, so a stale level proves nothing
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			phase <= 0;
			inClk <= 1'b0;
			outClk <= 1'b0;
			pat <= 16'h00b5;
		end else begin
			if (run) begin
				phase <= (phase == HALF - 1) ? 0 : phase + 1;
			end
			inClk <= inClkOe ? ~inClk : ((run && phase == HALF - 1) ? ~inClk : inClk);
			outClk <= outClkOe ? ~outClk : ((run && phase == HALF - 1) ? ~outClk : outClk);
			// data moves midway between edges, stable around either edge
			if (run && phase == HALF / 2 - 1) begin
				pat <= {pat[14:0], pat[15] ^ pat[13] ^ pat[12] ^ pat[10]};
			end
		end
	end

	assign data = pat[0];
endmodule
`default_nettype wire

// ---- verification/audio_port_clock_dividers_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module audio_port_clock_dividers_tb;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [31:0] prdata;
	logic        pready, pslverr;
	logic        dacModTick = 1'b0;
	logic        adcModTick = 1'b0;
	logic        pllNdivTick = 1'b0;
	logic        bitClkOut, bitClkOe, wordClkOut, wordClkOe;
	logic        densityInClkIn, densityInClkOut, densityInClkOe;
	logic        densityOutClkIn, densityOutClkOut, densityOutClkOe;
	logic        densityData, densitySample, densitySampleValid;
	logic        densityDividerPower, bitstreamDividerPower;
	logic [33:0] expQ[$];
	logic        pdmQ[$];
	logic [33:0] ex;
	logic [15:0] lf = 16'h51a2;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          tk = 0;
	int          nSamp = 0;
	logic        pdmOn = 1'b0;
	logic        edgeSel = 1'b0;
	logic        inPrev = 1'b0;
	logic        run = 1'b0;

	apcd_top u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dacModTick(dacModTick),
		.adcModTick(adcModTick), .pllNdivTick(pllNdivTick), .bitClkOut(bitClkOut),
		.bitClkOe(bitClkOe), .wordClkOut(wordClkOut), .wordClkOe(wordClkOe),
		.densityInClkIn(densityInClkIn), .densityInClkOut(densityInClkOut),
		.densityInClkOe(densityInClkOe), .densityOutClkIn(densityOutClkIn),
		.densityOutClkOut(densityOutClkOut), .densityOutClkOe(densityOutClkOe),
		.densityData(densityData), .densitySample(densitySample),
		.densitySampleValid(densitySampleValid), .densityDividerPower(densityDividerPower),
		.bitstreamDividerPower(bitstreamDividerPower));

	apcd_pdm_source #(.HALF(4)) u_src (.clk_sys(clk_sys), .rst(rst), .run(run),
		.inClkOe(densityInClkOe), .outClkOe(densityOutClkOe), .inClk(densityInClkIn),
		.outClk(densityOutClkIn), .data(densityData));

	// ------------------------------------------------------------
	// clock, source ticks
	// ------------------------------------------------------------
	always #10 clk_sys = ~clk_sys;

	// sources tick every 1, 2 and 3 cycles, so the period reveals the pick
	always @(posedge clk_sys) begin
		tk <= (tk + 1) % 6;
		dacModTick <= 1'b1;
		adcModTick <= (tk % 2 == 0);
		pllNdivTick <= (tk % 3 == 0);
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [11:0] ad(input int i);
		return 12'(i * 4);
	endfunction

	task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one apb transfer; e = {check data, expected error, expected data}
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s, input logic [33:0] e);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {lf, 8'h00, d};
		pstrb <= s;
		expQ.push_back(e);
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		// no wait-state count assumed; only the watchdog ends this wait
		while (pready !== 1'b1) @(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 4'hf, 34'h0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] v);
		apb(1'b0, a, 8'h00, 4'hf, {2'b10, 24'h0, v});
	endtask

	// cycles between the 2nd and 3rd rising edge, 0 if none
	task automatic period(input bit w, input int lim, output int p);
		int i, n, t0;
		logic pv, cv;
		n = 0;
		t0 = 0;
		p = 0;
		pv = 1'b1;
		for (i = 0; i < lim && n < 3; i++) begin
			@(posedge clk_sys);
			#1;
			cv = w ? wordClkOut : bitClkOut;
			if (cv === 1'b1 && pv === 1'b0) begin
				n++;
				if (n == 2) t0 = i;
				if (n == 3) p = i - t0;
			end
			pv = cv;
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// monitors
	// ------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (psel && penable && pready && expQ.size() > 0) begin
			ex = expQ.pop_front();
			check("pslverr", {33'h0, pslverr}, {33'h0, ex[32]});
			if (ex[33]) check("prdata", {2'b00, prdata}, {2'b00, ex[31:0]});
		end
	end

	// note the data at each chosen edge, compare on the sample pulse
	always @(posedge clk_sys) begin
		if (pdmOn && !densityInClkOe && densityInClkIn !== inPrev && densityInClkIn === ~edgeSel)
			pdmQ.push_back(densityData);
		inPrev <= densityInClkIn;
		if (pdmOn && densitySampleValid === 1'b1 && pdmQ.size() > 0) begin
			nSamp++;
			check("densitySample", {33'h0, densitySample}, {33'h0, pdmQ.pop_front()});
		end
	end

	initial begin
		repeat (90000) @(posedge clk_sys);
		n_fail++;
		$display("watchdog expired");
		test_done();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		int i, s, c, p;
		static logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h01, 8'h40, 8'h00, 8'h08, 8'h08};
		logic [7:0] wv[7];
		static logic [6:0] codes[3] = '{7'h20, 7'h00, 7'h7f};
		// power down first, so the stalled source starts from a cleared, low divider
		static logic [7:0] offS[3] = '{8'h00, 8'h03, 8'h00};
		static logic [7:0] offB[3] = '{8'h20, 8'ha0, 8'h85};
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		for (i = 0; i < 7; i++) rd(ad(8'h18 + i), rv[i]);
		$display("test reset values done");
		for (i = 0; i < 7; i++) begin
			lf = nx(lf);
			wv[i] = lf[7:0];
			wr(ad(8'h18 + i), wv[i]);
			rd(ad(8'h18 + i), wv[i]);
		end
		apb(1'b1, ad(8'h19), ~wv[1], 4'h0, 34'h0);
		rd(ad(8'h19), wv[1]);
		apb(1'b0, ad(8'h20), 8'h00, 4'hf, {2'b01, 32'h0});
		apb(1'b0, ad(8'h19) + 12'h001, 8'h00, 4'hf, {2'b01, 32'h0});
		apb(1'b1, ad(8'h1f), 8'hff, 4'hf, {2'b01, 32'h0});
		apb(1'b0, ad(8'h1f), 8'h00, 4'hf, 34'h0);
		$display("test register access done");
		for (i = 0; i < 4; i++) begin
			wr(ad(8'h18), 8'(i << 4));
			wr(ad(8'h1c), 8'(i));
			wr(ad(8'h1d), {i[0], 7'h08});
			wr(ad(8'h1e), {i[1], 7'h08});
			repeat (2) @(posedge clk_sys);
			#1;
			check("serialOe", {32'h0, wordClkOe, bitClkOe}, 34'(i));
			check("densityOe", {32'h0, densityInClkOe, densityOutClkOe}, 34'(i));
			check("power", {32'h0, bitstreamDividerPower, densityDividerPower}, 34'(i));
		end
		$display("test directions done");
		wr(ad(8'h1b), 8'h00);
		for (s = 0; s < 3; s++) begin
			for (c = 0; c < 3; c++) begin
				wr(ad(8'h19), 8'(s));
				wr(ad(8'h1a), {1'b1, codes[c]});
				period(1'b0, 1600, p);
				check("bitPeriod", 34'(p), 34'((s + 1) * (codes[c] == 0 ? 128 : codes[c])));
			end
		end
		for (c = 0; c < 3; c++) begin
			wr(ad(8'h19), offS[c]);
			wr(ad(8'h1a), offB[c]);
			period(1'b0, 1000, p);
			check("bitIdle", 34'(p), 34'h0);
			check("bitLow", {33'h0, bitClkOut}, 34'h0);
		end
		$display("test bit divider done");
		wr(ad(8'h19), 8'h00);
		wr(ad(8'h1a), 8'ha0);
		wr(ad(8'h1b), 8'ha0);
		period(1'b1, 4200, p);
		check("wordPeriod", 34'(p), 34'd1024);
		wr(ad(8'h1b), 8'h20);
		period(1'b1, 2500, p);
		check("wordIdle", 34'(p), 34'h0);
		wr(ad(8'h1b), 8'h9f);
		period(1'b1, 2500, p);
		check("wordRes", 34'(p), 34'h0);
		$display("test word divider done");
		for (i = 0; i < 2; i++) begin
			wr(ad(8'h1c), {5'h00, i[0], 2'b00});
			edgeSel = i[0];
			run <= 1'b1;
			repeat (10) @(posedge clk_sys);
			#1;
			pdmQ.delete();
			nSamp = 0;
			pdmOn = 1'b1;
			repeat (200) @(posedge clk_sys);
			#1;
			pdmOn = 1'b0;
			check("sampleCount", 34'(nSamp >= 20), 34'h1);
		end
		run <= 1'b0;
		$display("test pdm sampling done");
		test_done();
	end
endmodule
`default_nettype wire
